// ===== bench/eeprom_host_props.sv
// Purpose: Pin protocol checks for the EEPROM host
// Assumes: One clock domain, bound to eeprom_host
// Notes:   Helper counters restart whenever the host goes idle
`default_nettype none
`include "eeprom_host_defs.svh"
module eeprom_host_props
  import eeprom_host_pkg::*;
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic        i_req_valid,
  input wire op_t         i_req_op,
  input wire logic        o_req_ready,
  input wire logic        o_busy,
  input wire logic [12:0] o_addr,
  input wire logic [7:0]  o_dq,
  input wire logic        o_dq_oe,
  input wire logic        o_ce_n,
  input wire logic        o_oe_n,
  input wire logic        o_we_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = `BYTE_LOAD_GAP_CYC;
  logic [6:0]  n_q, pg_q;
  logic [1:0]  skip_q;
  logic [12:0] ra_q;
  logic [13:0] gap_q;
  logic        rv_q, we_q, oe_q;
  wire logic   tk = i_req_valid && o_req_ready;
  wire logic   wf = we_q && !o_we_n;
  wire logic   of = oe_q && !o_oe_n;
  // Count strobes and the gap since the last one; command strobes skipped
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      {n_q, pg_q, skip_q, ra_q, gap_q, rv_q, we_q, oe_q} <= '0;
    end else begin
      we_q <= o_we_n;
      oe_q <= o_oe_n;
      if (tk && !o_busy)
        skip_q <= (i_req_op inside {OP_PROTECT, OP_UNPROT}) ? 2'd3 : 2'd0;
      n_q <= !o_busy ? 7'd0 : n_q + 7'(wf);
      rv_q <= o_busy && (rv_q || of);
      if (of) ra_q <= o_addr;
      if (wf && n_q == 7'(skip_q)) pg_q <= o_addr[12:6];
      gap_q <= (wf || !o_busy) ? 14'd0 : gap_q + 14'(gap_q != 14'h3fff);
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  a_oe_high_write:
    assert property (!o_we_n && !o_ce_n |-> o_oe_n) else $error("oe low");
  a_bus_free_read:
    assert property (!o_oe_n |-> !o_dq_oe) else $error("dq clash");
  a_page_fixed:
    assert property (wf && n_q > 7'(skip_q) |-> o_addr[12:6] == pg_q)
      else $error("page moved");
  a_load_gap:
    assert property (wf && n_q > 0 |-> gap_q < GAP) else $error("gap long");
  a_ready_gap:
    assert property (o_busy && o_req_ready |-> gap_q < GAP)
      else $error("ready late");
  a_page_count:
    assert property (wf |-> n_q < 7'(skip_q) + 7'd64) else $error("too many");
  a_cmd_first:
    assert property (tk && !o_busy && i_req_op inside {OP_PROTECT, OP_UNPROT}
      |-> ##[1:6] (wf && o_addr == `CMD_ADDR_0 && o_dq == `CMD_DATA_0))
      else $error("bad command start");
  a_poll_addr:
    assert property (of && rv_q |-> o_addr == ra_q) else $error("poll moved");
  a_no_write_poll:
    assert property (rv_q |-> o_we_n) else $error("write while busy");
  c_full_page: cover property (wf && n_q == 7'd63);
  c_unprot: cover property (tk && i_req_op == OP_UNPROT);
  c_done: cover property ($fell(o_busy));
  c_gap_close: cover property (o_busy && o_req_ready && gap_q > 14'(GAP - 80));
endmodule
bind eeprom_host eeprom_host_props u_props (.I_CORE_CLK, .I_RST,
  .i_req_valid, .i_req_op, .o_req_ready, .o_busy, .o_addr, .o_dq,
  .o_dq_oe, .o_ce_n, .o_oe_n, .o_we_n);
`default_nettype wire

// ===== bench/eeprom_model.sv
// Purpose: Behavioural byte-wide EEPROM facing the host
// Assumes: Pins sampled on the core clock; program time shortened
// Notes:   A read also ends the load period, so polling sees busy
`default_nettype none
`include "eeprom_host_defs.svh"
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int PROG_NS = 4000,
  parameter int GAP_NS  = 150000
)
(
  input  wire logic        i_clk,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [7:0]  o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192];
  byte_t      ld [$];
  logic [7:0] last_d, rel_q;
  logic       busy = 1'b0, prot = 1'b0, tog = 1'b1, wp = 1'b1, rp, cmd;
  time        t_ld, t_end;
  wire logic  rd = !i_ce_n && !i_oe_n;
  // Released bus shows the inverse of the last value, never a hold
  assign o_dq = rd ? (busy ? {~last_d[7], tog, last_d[5:0]} : mem[i_addr])
                   : rel_q;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // Latch, time the load gap, program, then apply protect commands
  always @(posedge i_clk) begin
    wp <= i_we_n;
    rp <= rd;
    if (rd) rel_q <= ~o_dq;
    if (rd && !rp && busy) tog <= ~tog;
    if (!i_we_n && wp && !i_ce_n && !busy) begin
      ld.push_back('{i_addr, i_dq});
      t_ld = $time;
    end else if (!busy && ld.size() > 0 && (rd || $time - t_ld > GAP_NS)) begin
      last_d <= ld[$].data;
      busy <= 1'b1;
      t_end = $time + PROG_NS;
    end else if (busy && $time >= t_end) begin
      cmd = ld.size() >= 3 && ld[0] == {`CMD_ADDR_0, `CMD_DATA_0} &&
        ld[1] == {`CMD_ADDR_1, `CMD_DATA_1} && ld[2].addr == `CMD_ADDR_2;
      foreach (ld[i])
        if ((cmd || !prot) && (!cmd || i > 2)) mem[ld[i].addr] = ld[i].data;
      if (cmd && ld[2].data == `CMD_DATA_EN) prot = 1'b1;
      if (cmd && ld[2].data == `CMD_DATA_DIS) prot = 1'b0;
      ld.delete();
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== bench/parallel_eeprom_page_write_protect_tb.sv
// Purpose: Random page writes, protect and unprotect, with read-back
// Assumes: Model program time far below the host watchdog
// Notes:   Shadow array predicts contents from the protect state
`default_nettype none
module parallel_eeprom_page_write_protect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, last = 1'b0;
  op_t         op = OP_WRITE;
  byte_t       b = '0;
  logic        rdy, rv, busy, tmo, hoe, ce_n, oe_n, we_n, sp = 1'b0;
  logic [7:0]  rdat, hdq, mq, sh [8192];
  logic [12:0] a;
  int          err_count = 0, checks_done = 0;
  op_t         ops [7] = '{OP_WRITE, OP_WRITE, OP_PROTECT, OP_WRITE,
                           OP_PROTECT, OP_UNPROT, OP_WRITE};
  int          ns [7] = '{1, 64, 1, 0, 64, 0, 0};
  wire logic [7:0] dqw = hoe ? hdq : mq;
  eeprom_host dut (.I_CORE_CLK(clk), .I_RST(rst), .i_req_valid(vld),
    .i_req_op(op), .i_req_last(last), .i_req_byte(b), .o_req_ready(rdy),
    .o_rd_valid(rv), .o_rd_data(rdat), .o_busy(busy), .o_timeout(tmo),
    .o_addr(a), .o_dq(hdq), .o_dq_oe(hoe), .i_dq(dqw), .o_ce_n(ce_n),
    .o_oe_n(oe_n), .o_we_n(we_n));
  eeprom_model mdl (.i_clk(clk), .i_addr(a), .i_dq(dqw), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(mq));
  initial begin
    forever #10 clk = ~clk;
  end
  // Protected plain writes store nothing
  function automatic bit stores(op_t o);
    return o != OP_WRITE || !sp;
  endfunction
  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held from just after an edge until taken at a ready edge
  task automatic put(op_t o, logic l, logic [12:0] ad, logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    #1 op = o;
    last = l;
    b    = '{ad, d};
    vld  = 1'b1;
    @(negedge clk);
    while (rdy !== 1'b1 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    check("request ready", 8'h01, {7'h0, rdy});
    @(posedge clk);
    #1 vld = 1'b0;
  endtask
  task automatic rdchk(logic [12:0] ad);
    int k;
    k = 0;
    put(OP_READ, 1'b1, ad, 8'h00);
    while (rv !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    check("read valid", 8'h01, {7'h0, rv});
    check("read data", sh[ad], rdat);
  endtask
  // A cut page leaves last low, so the host closes it on the gap limit
  task automatic page(op_t o, int n, bit cut);
    logic [12:0] base, ad [$];
    logic [7:0]  d;
    bit          keep;
    int          k;
    base = 13'($urandom);
    keep = stores(o);
    for (int i = 0; i < n; i++) begin
      ad.push_back({base[12:6], base[5:0] + 6'(i)});
      d = 8'($urandom);
      put(i == 0 ? o : OP_WRITE, !cut && i == n - 1, ad[i], d);
      if (keep) sh[ad[i]] = d;
    end
    if (o != OP_WRITE) sp = (o == OP_PROTECT);
    k = 0;
    repeat (2) @(negedge clk);
    while (busy !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    check("busy end", 8'h00, {7'h0, busy});
    check("timeout flag", 8'h00, {7'h0, tmo});
    foreach (ad[i]) rdchk(ad[i]);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    int n;
    void'($urandom(32'h2291));
    foreach (sh[i]) sh[i] = 8'hff;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    foreach (ops[i]) begin
      n = ns[i] > 0 ? ns[i] : 1 + $urandom_range(62);
      page(ops[i], n, i == 6);
    end
    close_out();
  end
  // Watchdog well beyond the expected run
  initial begin
    // About 15k cycles expected, one cut page included
    #1ms;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire

// ===== rtl/eeprom_host.sv
// Purpose: Host controller that writes pages to a parallel EEPROM
// Assumes: Pins are asynchronous; read data passes two flip-flops
// Notes:   Toggle-bit polling marks end of write; timer caps the wait
`default_nettype none
`include "eeprom_host_defs.svh"

// Function
// [R01] Page select stays fixed during a load
// [R02] Next byte within byte load gap limit
// [R03] Gap overrun makes device start programming
// [R04] Enable sequence protects at write end
// [R05] Disable sequence unprotects at write end
// [R06] Protect sequence followed by 1..64 bytes
// [R07] Commands: 8-bit data, 13-bit addresses
// [R08] Unprefixed protected write only runs timer
// [R09] Output enable high while writing
// [R10] Polled bit 7 inverted until done
// [R11] Bit 6 toggles per read while busy
// [R12] Toggle advances on each read strobe
// [R13] Do not rely on bit 6 levels
// [R14] Keep polling address constant
// [R15] No new write until program time expires
module eeprom_host
  import eeprom_host_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  // Command port
  input  wire logic        i_req_valid,
  input  wire op_t         i_req_op,
  input  wire logic        i_req_last,
  input  wire byte_t       i_req_byte,
  output logic             o_req_ready,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data,
  output logic             o_busy,
  output logic             o_timeout,
  // Device pins
  output logic [12:0]      o_addr,
  output logic [7:0]       o_dq,
  output logic             o_dq_oe,
  input  wire logic [7:0]  i_dq,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n
);

  typedef struct packed {
    state_t      st;
    pins_t       pin;
    logic [19:0] cnt;        // Strobe phase timer
    logic [19:0] gap;        // Time since last load, saturating at 20'hfffff
    logic [19:0] prog;       // Program time watchdog
    logic [1:0]  cmd_idx;    // Position in command prefix
    logic        cmd_act;    // Prefix still being sent
    op_t         op;
    byte_t       hold;       // Byte being loaded
    logic [6:0]  loaded;     // Bytes of the page so far
    logic        last;
    logic        prev6_v;
    logic        prev6;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        timeout;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
  } st_t;

  st_t s_q;
  st_t s_d;

  // Address and data of one prefix step
  function automatic byte_t cmd_byte(input logic [1:0] idx, input op_t op);
    byte_t r;
    r.addr = (idx == 2'h0) ? `CMD_ADDR_0 :
             (idx == 2'h1) ? `CMD_ADDR_1 : `CMD_ADDR_2; // R07
    r.data = (idx == 2'h0) ? `CMD_DATA_0 :
             (idx == 2'h1) ? `CMD_DATA_1 :
             (op == OP_UNPROT) ? `CMD_DATA_DIS : `CMD_DATA_EN;
    return r;
  endfunction

  // Next state
  always_comb begin
    byte_t cb;
    // Decoded once so every path sees the same prefix step
    cb           = cmd_byte(s_q.cmd_idx, s_q.op);
    s_d          = s_q;
    s_d.sync1    = i_dq;           // First stage, read only by the second
    s_d.sync2    = s_q.sync1;
    s_d.rd_valid = 1'b0;
    s_d.cnt      = s_q.cnt + 20'h1;
    if (s_q.gap != 20'hfffff) begin
      s_d.gap = s_q.gap + 20'h1;
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.pin.ce_n  = 1'b1;
        s_d.pin.oe_n  = 1'b1;
        s_d.pin.we_n  = 1'b1;
        s_d.pin.dq_oe = 1'b0;
        if (i_req_valid) begin
          s_d.op      = i_req_op;
          s_d.hold    = i_req_byte;
          s_d.last    = i_req_last;
          s_d.loaded  = 7'h0;
          s_d.cmd_idx = 2'h0;
          s_d.cmd_act = (i_req_op == OP_PROTECT) || (i_req_op == OP_UNPROT);
          s_d.timeout = 1'b0;
          s_d.cnt     = 20'h0;
          s_d.st      = (i_req_op == OP_READ) ? ST_RLOW : ST_SETUP;
          s_d.pin.addr = i_req_byte.addr;
        end
      end
      ST_SETUP: begin
        // Output enable stays high through every write strobe
        s_d.pin.oe_n  = 1'b1; // R09
        s_d.pin.ce_n  = 1'b0;
        s_d.pin.dq_oe = 1'b1;
        if (s_q.cmd_act) begin
          s_d.pin.addr = cb.addr;
          s_d.pin.dq_o = cb.data;
        end else begin
          // Page select bits come from the first byte only
          s_d.pin.addr = (s_q.loaded == 7'h0) ? s_q.hold.addr :
                         {s_q.pin.addr[12:6], s_q.hold.addr[5:0]}; // R01
          s_d.pin.dq_o = s_q.hold.data;
        end
        s_d.pin.we_n = 1'b0;
        s_d.cnt      = 20'h0;
        s_d.st       = ST_LOW;
      end
      ST_LOW: begin
        if (s_q.cnt >= 20'(`WRITE_PULSE_CYC - 1)) begin
          s_d.pin.we_n = 1'b1;
          s_d.cnt      = 20'h0;
          s_d.gap      = 20'h0;
          s_d.st       = ST_HIGH;
        end
      end
      ST_HIGH: begin
        s_d.pin.ce_n = 1'b1;
        if (s_q.cnt >= 20'(`PULSE_HIGH_CYC - 1)) begin
          s_d.pin.dq_oe = 1'b0;
          if (s_q.cmd_act) begin
            s_d.cmd_idx = s_q.cmd_idx + 2'h1;
            s_d.cmd_act = (s_q.cmd_idx != 2'h2);
            s_d.st      = ST_SETUP; // R04 R05
          end else begin
            // Page end is decided in the gap state from last, count and gap time
            s_d.loaded = s_q.loaded + 7'h1;
            s_d.st     = ST_GAP; // R06
          end
        end
      end
      ST_GAP: begin
        // Next byte must come well inside the load gap limit
        if (!s_q.last && s_q.loaded != 7'(`PAGE_BYTES) && i_req_valid &&
            s_q.gap < 20'(`BYTE_LOAD_GAP_CYC - 64)) begin // R02
          s_d.hold = i_req_byte;
          s_d.last = i_req_last;
          s_d.st   = ST_SETUP;
        end else if (s_q.last || s_q.loaded == 7'(`PAGE_BYTES) ||
                     s_q.gap >= 20'(`BYTE_LOAD_GAP_CYC - 64)) begin
          // Loading closed: the device starts its program cycle
          s_d.prog    = 20'h0; // R03
          s_d.prev6_v = 1'b0;
          s_d.pin.addr = s_q.pin.addr; // R14
          s_d.cnt     = 20'h0;
          s_d.st      = ST_RHIGH;
        end
      end
      ST_RLOW: begin
        s_d.pin.ce_n = 1'b0;
        s_d.pin.oe_n = 1'b0;
        if (s_q.cnt >= 20'(`READ_ACCESS_CYC + 2)) begin
          s_d.pin.oe_n = 1'b1;
          s_d.pin.ce_n = 1'b1;
          s_d.cnt      = 20'h0;
          if (s_q.op == OP_READ) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = s_q.sync2;
            s_d.st       = ST_IDLE;
          end else begin
            s_d.prev6   = s_q.sync2[6];
            s_d.prev6_v = 1'b1;
            // Two equal samples mean the device finished; levels ignored
            if (s_q.prev6_v && s_q.prev6 == s_q.sync2[6]) begin // R11 R13
              s_d.st = ST_IDLE;
            end else begin
              s_d.st = ST_RHIGH;
            end
          end
        end
      end
      ST_RHIGH: begin
        // Each read strobe while the device is busy advances its toggle bit
        if (s_q.cnt >= 20'(`OE_HIGH_CYC - 1)) begin // R12
          s_d.cnt = 20'h0;
          s_d.st  = ST_RLOW;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Watchdog past the program time; no new write before it ends
    if (s_q.st == ST_RLOW || s_q.st == ST_RHIGH) begin
      s_d.prog = s_q.prog + 20'h1;
      if (s_q.op != OP_READ && s_q.prog >= 20'(`PROGRAM_TIME_CYC)) begin // R15
        s_d.timeout = 1'b1;
        s_d.pin.oe_n = 1'b1;
        s_d.pin.ce_n = 1'b1;
        s_d.st       = ST_IDLE;
      end
    end
  end

  // State register
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.pin.ce_n <= 1'b1;
      s_q.pin.oe_n <= 1'b1;
      s_q.pin.we_n <= 1'b1;
      s_q.op      <= OP_WRITE;
    end else begin
      s_q <= s_d;
    end
  end

  // Ready to take the first byte, or the next byte of a page
  assign o_req_ready = (s_q.st == ST_IDLE) ||
    (s_q.st == ST_GAP && !s_q.last && s_q.loaded != 7'(`PAGE_BYTES) &&
     s_q.gap < 20'(`BYTE_LOAD_GAP_CYC - 64));
  assign o_rd_valid = s_q.rd_valid;
  assign o_rd_data  = s_q.rd_data;
  assign o_busy     = (s_q.st != ST_IDLE);
  assign o_timeout  = s_q.timeout;
  assign o_addr     = s_q.pin.addr;
  assign o_dq       = s_q.pin.dq_o;
  assign o_dq_oe    = s_q.pin.dq_oe;
  assign o_ce_n     = s_q.pin.ce_n;
  assign o_oe_n     = s_q.pin.oe_n;
  assign o_we_n     = s_q.pin.we_n;

endmodule
`default_nettype wire

// ===== rtl/eeprom_host_defs.svh
// Purpose: Timing counts and command constants for the EEPROM host
// Assumes: 50 MHz core clock (20 ns period)
// Notes:   Times kept in their printed unit; cycle counts derived here
`ifndef EEPROM_HOST_DEFS_SVH
`define EEPROM_HOST_DEFS_SVH

`define CLK_PERIOD_NS      20
// Strobe low width: at least 100 ns, rounded up
`define WRITE_PULSE_NS     100
`define WRITE_PULSE_CYC    ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Strobe high width between loads: at least 50 ns
`define PULSE_HIGH_NS      50
`define PULSE_HIGH_CYC     ((`PULSE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Read access: at most 150 ns, sampling waits the full figure
`define READ_ACCESS_NS     150
`define READ_ACCESS_CYC    ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Output enable high between polling reads: at least 150 ns
`define OE_HIGH_NS         150
`define OE_HIGH_CYC        ((`OE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Gap limit between page loads: 150 us, longest gap rounds down
`define BYTE_LOAD_GAP_US   150
`define BYTE_LOAD_GAP_CYC  ((`BYTE_LOAD_GAP_US * 1000) / `CLK_PERIOD_NS)
// Internal program time: 10 ms maximum
`define PROGRAM_TIME_MS    10
`define PROGRAM_TIME_CYC   ((`PROGRAM_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`define PAGE_BYTES         64
// Three-step protect command sequence, address then data
`define CMD_ADDR_0         13'h1555
`define CMD_ADDR_1         13'h0aaa
`define CMD_ADDR_2         13'h1555
`define CMD_DATA_0         8'haa
`define CMD_DATA_1         8'h55
`define CMD_DATA_EN        8'ha0
`define CMD_DATA_DIS       8'h80

`endif

// ===== rtl/eeprom_host_pkg.sv
// Purpose: Types shared by the EEPROM host controller
// Assumes: 8K x 8 array, 64-byte pages
// Notes:   Constants live in eeprom_host_defs.svh
`default_nettype none
package eeprom_host_pkg;

  typedef enum logic [1:0] {
    OP_WRITE   = 2'h0,  // Plain page write
    OP_PROTECT = 2'h1,  // Enable protection, then page write
    OP_UNPROT  = 2'h2,  // Disable protection, then page write
    OP_READ    = 2'h3
  } op_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } byte_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  dq_o;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } pins_t;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SETUP = 8'h02,
    ST_LOW   = 8'h04,
    ST_HIGH  = 8'h08,
    ST_GAP   = 8'h10,
    ST_POLL  = 8'h20,
    ST_RLOW  = 8'h40,
    ST_RHIGH = 8'h80
  } state_t;

endpackage
`default_nettype wire
